// File: logic/strap_pkg.sv
// Purpose: shared constants, carriers and states for the strap sampler.
// Assumes: one 100 MHz clock, a 16-bit register port in the low bits.
// Notes: pin order in strap_s follows the physical strap grouping.
package strap_pkg;

	// register offsets on the plain register port
	localparam logic [7:0] REG_BASIC_CONTROL = 8'h00;
	localparam logic [7:0] REG_AN_ADVERT = 8'h04;
	localparam logic [7:0] REG_PHY_CONTROL = 8'h08;
	localparam logic [7:0] REG_STRAP_STATUS = 8'h0c;

	// basic control field positions
	localparam int CTRL_SPEED_BIT = 13;
	localparam int CTRL_AUTONEG_ENABLE_STRAP_BIT = 12;
	localparam int CTRL_ISOLATE_BIT = 10;
	localparam int CTRL_DUPLEX_BIT = 8;
	localparam logic [15:0] CTRL_WRITE_MASK = 16'h3500;

	// advertisement field positions and fixed selector
	localparam int ADV_ABILITY_LSB = 5;
	localparam logic [15:0] ADV_WRITE_MASK = 16'h01e0;
	localparam logic [4:0] ADV_SELECTOR = 5'h01;

	// phy control address field position
	localparam int PHY_CONTROL_REG_ADDR_LSB = 0;

	// values after reset, before the straps are loaded, and the isolating address
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] ADV_RESET = 16'h0000;
	localparam logic [4:0] ADDR_RESET = 5'h00;
	localparam logic [4:0] ISOLATE_ADDR = 5'h00;

	// capability strap codes
	localparam logic [1:0] CAP_10_HALF = 2'h0;
	localparam logic [1:0] CAP_10_FULL = 2'h1;
	localparam logic [1:0] CAP_100_HALF = 2'h2;
	localparam logic [1:0] CAP_100_FULL = 2'h3;

	// cycles the released pins settle through the synchroniser
	localparam logic [1:0] SETTLE_CYCLES = 2'h2;

	// strap pins, one bit each, in pad order
	typedef struct packed {
		logic [4:0] mgmt_addr_strap;
		logic autoneg_enable_strap;
		logic capability_strap_hi;
		logic capability_strap_lo;
	} strap_s;

	// weak internal pulls: 1 is pull-up, 0 is pull-down
	localparam strap_s STRAP_PULL_DEFAULT = '{
		mgmt_addr_strap: 5'h01,
		autoneg_enable_strap: 1'b1,
		capability_strap_hi: 1'b1,
		capability_strap_lo: 1'b1
	};

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	// loader sequence after reset
	typedef enum logic [1:0] {
		ST_SETTLE,
		ST_LATCH,
		ST_RUN
	} load_state_e;

endpackage : strap_pkg

// File: logic/strap_sync.sv
// Purpose: two-stage synchroniser for the strap pads.
// Assumes: pads are asynchronous to clk_sys.
// Notes: no reset, so the pads flow through while reset_n is held low.
`timescale 1ns/10ps
module strap_sync (
	// clock
	input wire logic clk_sys,
	// raw pads
	input wire strap_pkg::strap_s pad_in,
	// synchronised levels
	output strap_pkg::strap_s pad_sync
);
	import strap_pkg::*;

	strap_s stage1; // first stage, read only by stage two

	// plain double flop, runs during reset
	always_ff @(posedge clk_sys) begin
		stage1 <= pad_in;
		pad_sync <= stage1;
	end

endmodule : strap_sync

// File: logic/strap_decode.sv
// Purpose: turns capability straps into speed, duplex and advertisement.
// Assumes: purely combinational.
// Notes: advertisement order is 100 full, 100 half, 10 full, 10 half.
`timescale 1ns/10ps
module strap_decode (
	// capability code
	input wire logic [1:0] cap,
	// forced settings
	output logic speed_100,
	output logic full_duplex,
	// advertised abilities
	output logic [3:0] adv_ability
);
	import strap_pkg::*;

	// forced table and advertised set per code
	always_comb begin
		speed_100 = 1'b0;
		full_duplex = 1'b0;
		adv_ability = 4'h1;
		case (cap)
			CAP_10_HALF: begin
				adv_ability = 4'h1;
			end
			CAP_10_FULL: begin
				full_duplex = 1'b1;
				adv_ability = 4'h3;
			end
			CAP_100_HALF: begin
				speed_100 = 1'b1;
				adv_ability = 4'h5;
			end
			default: begin
				speed_100 = 1'b1;
				full_duplex = 1'b1;
				adv_ability = 4'hf;
			end
		endcase
	end

endmodule : strap_decode

// File: logic/phy_strap_sampler.sv
// Purpose: captures strap levels at hardware reset and loads the config.
// Assumes: pads are released during reset; board resistors set levels.
// Notes: pads are driven with functional outputs only after loading.
//   straps are read once per reset; later pad changes are ignored.
//   software writes are dropped until the loaded config is valid.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps

// What this block does
// - sample all strap pins during reset, configure.
// - latch five address straps, bit 0 lowest.
// - accept any strapped address zero to thirty-one.
// - strapped zero isolates; written zero does not.
// - address bit 0 pulled up, 4:1 down.
// - autoneg strap high: negotiate, advertise capability.
// - autoneg strap low: forced speed and duplex.
// - after reset drive led pins, and mii pins unless isolated, with functional outputs.
// - load straps into control and advertisement registers.
module phy_strap_sampler (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// strap pads
	input wire strap_pkg::strap_s pin_in,
	output strap_pkg::strap_s pin_out,
	output strap_pkg::strap_s pin_oe_n,
	output strap_pkg::strap_s pin_pull_up,
	// functional sources for the shared pads
	input wire logic mii_col,
	input wire logic [3:0] mii_rxd,
	input wire logic activity_indicator_pin,
	input wire logic speed_indicator_pin,
	input wire logic link_indicator_pin,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// loaded configuration
	output logic config_valid,
	output logic [4:0] mgmt_addr,
	output logic isolate_active,
	output logic autoneg_enabled,
	output logic speed_100,
	output logic full_duplex
);
	import strap_pkg::*;

	// one-hot select of the mapped registers, zero when unmapped;
	// shared by the write path and the read path
	function automatic logic [3:0] reg_select(input logic [7:0] addr);
		logic [3:0] sel;
		sel = 4'h0;
		if (addr == REG_BASIC_CONTROL) begin
			sel[0] = 1'b1;
		end else if (addr == REG_AN_ADVERT) begin
			sel[1] = 1'b1;
		end else if (addr == REG_PHY_CONTROL) begin
			sel[2] = 1'b1;
		end else if (addr == REG_STRAP_STATUS) begin
			sel[3] = 1'b1;
		end
		return sel;
	endfunction : reg_select

	// synchronised pads and decode results
	// decode is fed from the captured straps, not the live pads
	strap_s pin_sync;
	logic dec_speed_100;
	logic dec_full_duplex;
	logic [3:0] dec_adv;
	reg_req_s req;
	logic [3:0] req_sel; // one-hot register select

	// loader state
	// settle_cnt counts the flush of the sync pipe
	load_state_e state;
	load_state_e next_state;
	logic [1:0] settle_cnt;
	logic [1:0] next_settle_cnt;
	strap_s captured;
	strap_s next_captured;

	// configuration registers
	// all three live on clk_sys and reset to zero
	logic [15:0] basic_control;
	logic [15:0] next_basic_control;
	logic [15:0] an_advert;
	logic [15:0] next_an_advert;
	logic [15:0] phy_control_reg;
	logic [15:0] next_phy_control_reg;
	logic [15:0] next_reg_rdata;

	// pad drive
	// oe_n is low while the block drives a pad
	strap_s next_pin_out;
	strap_s next_pin_oe_n;

	// weak pulls are fixed by the pad ring
	// the board sees this map on every released pad
	assign pin_pull_up = STRAP_PULL_DEFAULT;

	// bundle the port request
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// one decode feeds both the write and the read chain
	assign req_sel = reg_select(req.addr);

	// pads cross into clk_sys through two flops
	// the pipe has no reset, so it fills while reset_n is low
	strap_sync u_sync (
		.clk_sys(clk_sys),
		.pad_in(pin_in),
		.pad_sync(pin_sync)
	);

	// capability table, taken from the captured straps
	// results are only used in the latch cycle
	strap_decode u_decode (
		.cap({captured.capability_strap_hi, captured.capability_strap_lo}),
		.speed_100(dec_speed_100),
		.full_duplex(dec_full_duplex),
		.adv_ability(dec_adv)
	);

	// loader: wait for the pipe, capture, then run
	// the sync pipe needs two edges to flush reset-time levels
	// capture after that cannot see a half-settled pad
	// pads stay released until the latch cycle ends
	// one capture per reset, nothing re-arms it but reset_n
	always_comb begin
		next_state = state;
		next_settle_cnt = settle_cnt;
		next_captured = captured;
		case (state)
			ST_SETTLE: begin
				// pads still released, sync pipe holds reset-time levels
				if (settle_cnt == SETTLE_CYCLES) begin
					next_captured = pin_sync;
					next_state = ST_LATCH;
				end else begin
					next_settle_cnt = settle_cnt + 2'h1;
				end
			end
			ST_LATCH: begin
				// registers take the captured straps this cycle
				next_state = ST_RUN;
			end
			default: begin
				// straps no longer read until the next reset
				next_state = ST_RUN;
			end
		endcase
	end

	// loader registers
	// captured clears on reset so a stale strap set
	// never survives into the next load
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_SETTLE;
			settle_cnt <= 2'h0;
			captured <= '0;
		end else begin
			state <= next_state;
			settle_cnt <= next_settle_cnt;
			captured <= next_captured;
		end
	end

	// register load from straps and software writes
	// strap load owns the registers in the latch cycle
	// writes before running are dropped, with no error
	// isolate comes only from a strapped zero address
	// or from software through the control bit
	always_comb begin
		next_basic_control = basic_control;
		next_an_advert = an_advert;
		next_phy_control_reg = phy_control_reg;
		if (state == ST_LATCH) begin
			// strap load into control and advertisement
			next_basic_control = CTRL_RESET;
			next_basic_control[CTRL_AUTONEG_ENABLE_STRAP_BIT] = captured.autoneg_enable_strap;
			// forced speed and duplex from the capability pair
			next_basic_control[CTRL_SPEED_BIT] = dec_speed_100;
			next_basic_control[CTRL_DUPLEX_BIT] = dec_full_duplex;
			// only a strapped zero address isolates
			next_basic_control[CTRL_ISOLATE_BIT] =
				(captured.mgmt_addr_strap == ISOLATE_ADDR);
			next_an_advert = ADV_RESET;
			next_an_advert[ADV_ABILITY_LSB +: 4] = dec_adv;
			next_an_advert[4:0] = ADV_SELECTOR;
			next_phy_control_reg = 16'h0000;
			next_phy_control_reg[PHY_CONTROL_REG_ADDR_LSB +: 5] = captured.mgmt_addr_strap;
		end else if (state == ST_RUN && req.wr) begin
			// writes before loading ends are ignored
			if (req_sel[0]) begin
				next_basic_control = req.wdata & CTRL_WRITE_MASK;
			end else if (req_sel[1]) begin
				next_an_advert = (req.wdata & ADV_WRITE_MASK) | {11'h000, ADV_SELECTOR};
			end else if (req_sel[2]) begin
				// a written zero address leaves isolate alone
				next_phy_control_reg = {11'h000, req.wdata[PHY_CONTROL_REG_ADDR_LSB +: 5]};
			end
		end
	end

	// configuration registers
	// reset values hold until the latch cycle loads the straps
	// a new reset clears any software setting
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			basic_control <= CTRL_RESET;
			an_advert <= ADV_RESET;
			phy_control_reg <= {11'h000, ADDR_RESET};
		end else begin
			basic_control <= next_basic_control;
			an_advert <= next_an_advert;
			phy_control_reg <= next_phy_control_reg;
		end
	end

	// read data for the cycle after the strobe, zero otherwise
	// unmapped addresses and idle cycles read zero,
	// so a stale word never lingers on the bus
	// the status word is read only, writes to it fall through
	// one cycle of data, then back to zero
	always_comb begin
		next_reg_rdata = 16'h0000;
		if (req.rd) begin
			if (req_sel[0]) begin
				next_reg_rdata = basic_control;
			end else if (req_sel[1]) begin
				next_reg_rdata = an_advert;
			end else if (req_sel[2]) begin
				next_reg_rdata = phy_control_reg;
			end else if (req_sel[3]) begin
				// raw captured levels and load-done flag
				next_reg_rdata = {7'h00, config_valid, captured};
			end
		end
	end

	// read data register
	// the master never waits: data always one edge after the strobe
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

	// pad drive: released until running, mii pads released while isolated
	// functional values run whenever reset_n is high;
	// only the enables gate them onto the pads
	// enables fall in the latch cycle, one edge after capture
	// isolated: mii pads stay released, leds stay driven
	// isolate follows the next control value, so a write acts at once
	always_comb begin
		next_pin_out.mgmt_addr_strap = {mii_rxd, mii_col};
		next_pin_out.autoneg_enable_strap = activity_indicator_pin;
		next_pin_out.capability_strap_hi = speed_indicator_pin;
		next_pin_out.capability_strap_lo = link_indicator_pin;
		next_pin_oe_n = '1;
		if (next_state == ST_RUN && state != ST_SETTLE) begin
			// functional outputs take over the shared pads
			next_pin_oe_n.autoneg_enable_strap = 1'b0;
			next_pin_oe_n.capability_strap_hi = 1'b0;
			next_pin_oe_n.capability_strap_lo = 1'b0;
			if (!next_basic_control[CTRL_ISOLATE_BIT]) begin
				next_pin_oe_n.mgmt_addr_strap = 5'h00;
			end
		end
	end

	// pad registers, released under reset
	// async release keeps the board straps readable at once
	// registered so the pads never glitch on decode
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pin_out <= '0;
			pin_oe_n <= '1;
		end else begin
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
		end
	end

	// configuration seen by the rest of the device
	// straight from the register bits, so software writes
	// take effect on the cycle after the write strobe
	// config_valid rises with the run state and stays until reset
	assign config_valid = (state == ST_RUN);
	assign mgmt_addr = phy_control_reg[PHY_CONTROL_REG_ADDR_LSB +: 5];
	assign isolate_active = basic_control[CTRL_ISOLATE_BIT];
	assign autoneg_enabled = basic_control[CTRL_AUTONEG_ENABLE_STRAP_BIT];
	assign speed_100 = basic_control[CTRL_SPEED_BIT];
	assign full_duplex = basic_control[CTRL_DUPLEX_BIT];

endmodule : phy_strap_sampler

// File: tb/phy_strap_sampler_monitor.sv
// Purpose: port assertions for the strap sampler.
// Assumes: one clock, reset_n async active low.
// Notes: strap_seen follows the pads until loading ends.
`timescale 1ns/10ps
module phy_strap_sampler_monitor (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// pads and functional sources
	input wire strap_pkg::strap_s pin_in,
	input wire strap_pkg::strap_s pin_out,
	input wire strap_pkg::strap_s pin_oe_n,
	input wire logic mii_col,
	input wire logic [3:0] mii_rxd,
	input wire logic activity_indicator_pin,
	input wire logic speed_indicator_pin,
	input wire logic link_indicator_pin,
	// register port and loaded config
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic config_valid,
	input wire logic [4:0] mgmt_addr,
	input wire logic isolate_active,
	input wire logic autoneg_enabled,
	input wire logic speed_100,
	input wire logic full_duplex
);
	import strap_pkg::*;
	strap_s strap_seen; // pad levels seen while loading
	logic [7:0] func_src; // functional sources in pad order
	assign func_src = {mii_rxd, mii_col, activity_indicator_pin, speed_indicator_pin,
		link_indicator_pin};
	// follow pads until the config is loaded
	always_ff @(posedge clk_sys) begin
		if (!config_valid) begin
			strap_seen <= pin_in;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	AST_OE_LOADING: assert property (!config_valid |-> pin_oe_n == 8'hff)
		else $error("pads driven while loading");
	AST_LED_DRIVEN: assert property (config_valid |-> pin_oe_n[2:0] == 3'h0)
		else $error("indicator pads not driven");
	AST_MII_RELEASE: assert property (config_valid |->
		pin_oe_n.mgmt_addr_strap == {5{isolate_active}})
		else $error("mii pad enable does not follow isolate");
	AST_PIN_FUNC: assert property (config_valid ##1 config_valid |-> pin_out == $past(func_src))
		else $error("pad output not functional source");
	AST_LOAD_TIME: assert property ($rose(reset_n) |-> !config_valid [*4] ##1 config_valid)
		else $error("config load timing off");
	AST_CFG_HOLD: assert property (config_valid |=> config_valid)
		else $error("config valid dropped");
	AST_STRAP_LOAD: assert property ($rose(config_valid) |->
		mgmt_addr == strap_seen.mgmt_addr_strap
		&& autoneg_enabled == strap_seen.autoneg_enable_strap)
		else $error("strap address or autoneg not loaded");
	AST_FORCED_MODE: assert property ($rose(config_valid) |-> {speed_100, full_duplex} ==
		{strap_seen.capability_strap_hi, strap_seen.capability_strap_lo})
		else $error("speed or duplex not from straps");
	AST_ISOLATE_LOAD: assert property ($rose(config_valid) |->
		isolate_active == (mgmt_addr == 5'h00))
		else $error("isolate load wrong");
	AST_ADDR_HOLD: assert property (config_valid && $past(config_valid) && !$past(reg_wr)
		|-> $stable(mgmt_addr))
		else $error("address moved without write");
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside read cycle");
	// main scenarios
	cover property ($rose(config_valid) && isolate_active);
	cover property ($rose(config_valid) && !autoneg_enabled);
	cover property ($rose(config_valid) && mgmt_addr == 5'h1f);
endmodule : phy_strap_sampler_monitor

bind phy_strap_sampler phy_strap_sampler_monitor mon_u (.clk_sys, .reset_n, .pin_in, .pin_out,
	.pin_oe_n, .mii_col, .mii_rxd, .activity_indicator_pin, .speed_indicator_pin,
	.link_indicator_pin, .reg_wr, .reg_rd, .reg_rdata, .config_valid, .mgmt_addr,
	.isolate_active, .autoneg_enabled, .speed_100, .full_duplex);

// File: tb/strap_board.sv
// Purpose: board resistors and pad resolution around the sampler.
// Assumes: a fitted resistor beats the weak internal pull.
// Notes: a driven pad shows the driver, never the strap.
`timescale 1ns/10ps
module strap_board (
	// pad control from the sampler
	input wire strap_pkg::strap_s pin_out,
	input wire strap_pkg::strap_s pin_oe_n,
	input wire strap_pkg::strap_s pin_pull_up,
	// fitted resistors and their levels
	input wire logic [7:0] fitted,
	input wire logic [7:0] level,
	// resolved pads
	output strap_pkg::strap_s pin_in
);
	import strap_pkg::*;
	// per pad: driver, else resistor, else weak pull
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_n[i]) begin
				pin_in[i] = pin_out[i];
			end else if (fitted[i]) begin
				pin_in[i] = level[i];
			end else begin
				pin_in[i] = pin_pull_up[i];
			end
		end
	end
endmodule : strap_board

// File: tb/phy_strap_sampler_tb.sv
// Purpose: self-checking bench for the strap sampler.
// Assumes: board model resolves pads.
// Notes: rows are {fitted, level} strap settings.
`timescale 1ns/10ps
module phy_strap_sampler_tb;
	import strap_pkg::*;
	logic clk_sys = 0, reset_n = 0, mii_col = 0, act = 0, spd = 0, lnk = 0;
	logic reg_wr = 0, reg_rd = 0, config_valid, isolate_active, autoneg_enabled;
	logic speed_100, full_duplex;
	logic [3:0] mii_rxd = 4'h0;
	logic [7:0] reg_addr = 8'h00, fitted = 8'h00, level = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd;
	logic [4:0] mgmt_addr;
	strap_s pin_in, pin_out, pin_oe_n, pin_pull_up, s;
	logic [3:0] ab;
	int n_errors = 0, total_checks = 0;
	// ordinary cases: default, each code, address 0 and 31
	logic [15:0] rows [6] = '{16'h0000, 16'hff00, 16'hfff9, 16'hff52, 16'hffaf, 16'hff14};
	always #5 clk_sys = ~clk_sys;
	phy_strap_sampler dut_u (.clk_sys, .reset_n, .pin_in, .pin_out, .pin_oe_n, .pin_pull_up,
		.mii_col, .mii_rxd, .activity_indicator_pin(act), .speed_indicator_pin(spd),
		.link_indicator_pin(lnk), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.config_valid, .mgmt_addr, .isolate_active, .autoneg_enabled, .speed_100,
		.full_duplex);
	strap_board board_u (.pin_out, .pin_oe_n, .pin_pull_up, .fitted, .level, .pin_in);
	task automatic check_value(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_value
	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask : reg_read
	task automatic do_reset(input logic [15:0] r);
		@(posedge clk_sys);
		reset_n <= 1'b0;
		fitted <= r[15:8];
		level <= r[7:0];
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		for (int k = 0; k < 20 && config_valid !== 1'b1; k++) @(posedge clk_sys);
		#1 s = (r[15:8] & r[7:0]) | (~r[15:8] & STRAP_PULL_DEFAULT);
	endtask : do_reset
	task automatic report_and_stop();
		if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (3000) @(posedge clk_sys);
		n_errors++;
		report_and_stop();
	end
	initial begin
		foreach (rows[i]) begin
			do_reset(rows[i]);
			ab = s.capability_strap_lo ? 4'h3 : 4'h1;
			if (s.capability_strap_hi) ab = s.capability_strap_lo ? 4'hf : 4'h5;
			check_value({11'h0, mgmt_addr}, {11'h0, s.mgmt_addr_strap});
			check_value({15'h0, isolate_active}, {15'h0, s.mgmt_addr_strap == 5'h00});
			check_value({15'h0, autoneg_enabled}, {15'h0, s.autoneg_enable_strap});
			check_value({14'h0, speed_100, full_duplex}, {14'h0, s[1:0]});
			reg_read(REG_BASIC_CONTROL);
			check_value(rd, {2'h0, s[1], s[2], 1'b0, s[7:3] == 5'h00, 1'b0, s[0], 8'h00});
			reg_read(REG_AN_ADVERT);
			check_value(rd, {7'h0, ab, ADV_SELECTOR});
			reg_read(REG_STRAP_STATUS);
			check_value(rd, {8'h01, s});
		end
		// pads changed after capture are ignored, pads carry functions
		do_reset(16'hfff9);
		@(posedge clk_sys);
		level <= 8'h00;
		mii_rxd <= 4'ha;
		mii_col <= 1'b1;
		spd <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 check_value({11'h0, mgmt_addr}, 16'h001f);
		check_value({8'h00, pin_in}, 16'h00aa);
		// a written zero address never isolates
		reg_write(REG_PHY_CONTROL, 16'h0000);
		#1 check_value({10'h0, mgmt_addr, isolate_active}, 16'h0000);
		reg_write(REG_AN_ADVERT, 16'hffff);
		reg_read(REG_AN_ADVERT);
		check_value(rd, 16'h01e1);
		reg_write(REG_BASIC_CONTROL, 16'hffff);
		#1 check_value({15'h0, isolate_active}, 16'h0001);
		reg_read(8'h10);
		check_value(rd, 16'h0000);
		report_and_stop();
	end
endmodule : phy_strap_sampler_tb
